// ### rtl/csr_core_regs.sv
// Purpose: Core special registers: accumulator, status word, stack top
//          pointer and the two data pointer bytes.
// Assumes: Inputs synchronous to CORE_CLK_IN; one access per cycle.
// Notes:   Direct special register reads answer one cycle later.
//
// Contract
// - Low data pointer byte forms pointer low
// - High byte forms upper; both reset zero
// - Stack top pointer resets to 0x07
// - Push increments stack pointer before write
// - Carry set on carry or borrow
// - Aux carry set on nibble carry or borrow
// - Two user flags changed only by software
// - Bank select bits choose register bank base
// - Signed overflow on add or subtract
// - Overflow when product exceeds 255
// - Overflow on divide by zero
// - Otherwise those operations clear overflow
// - Parity bit is read only
// - Eight-bit accumulator resets to zero
// - Bit access only at addresses x0, x8
`default_nettype none

module csr_core_regs
  import csr_pkg::*;
#(
  parameter int DATA_W = CSR_DATA_W  // Register width; only 8 is served.
)
(
  // Clock and reset.
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  // Direct special register access.
  input  wire logic [7:0]  SFR_ADDR_IN,
  input  wire logic        SFR_WR_IN,
  input  wire logic        SFR_RD_IN,
  input  wire logic [7:0]  SFR_WDATA_IN,
  input  wire logic        SFR_BIT_IN,
  input  wire logic [2:0]  SFR_BIT_POS_IN,
  output logic [7:0]       SFR_RDATA_OUT,
  output logic             SFR_RD_HIT_OUT,
  // Arithmetic request from the core.
  input  wire csr_alu_op_t ALU_OP_IN,
  input  wire logic [7:0]  ALU_OPERAND_IN,
  output logic [7:0]       ALU_AUX_OUT,
  // Stack requests from the core.
  input  wire logic        PUSH_IN,
  input  wire logic        POP_IN,
  // Views of the register contents.
  output logic [15:0]      DATA_POINTER_OUT,
  output logic [7:0]       STACK_TOP_OUT,
  output logic [7:0]       ACCUMULATOR_OUT,
  output logic [7:0]       STATUS_WORD_OUT,
  output logic [7:0]       BANK_BASE_OUT
);

  // Refuse widths the byte-wide decode cannot serve.
  if (DATA_W != 8)
  begin : g_width_check
    $error("csr_core_regs supports only an 8-bit data width.");
  end

  csr_state_t   st_ff;      // Registered state.
  csr_state_t   nxt_st;     // Next state.
  csr_alu_res_t alu_res;    // Outcome of the current arithmetic request.
  logic         bit_ok;     // Bit access allowed at this address.
  logic         wr_en;      // Effective write is taking place.
  logic [7:0]   wr_mask;    // Bits changed by this write.
  logic [7:0]   wr_val;     // Data aligned to the written bits.
  logic [7:0]   psw_now;    // Status word as stored now.
  logic [7:0]   psw_new;    // Status word after a software write.

  // Odd number of ones gives a high parity bit.
  function automatic logic odd_parity(input logic [7:0] val);
    odd_parity = ^val;
  endfunction

  // Merge written bits into an old byte under a mask.
  function automatic logic [7:0] merge_bits(input logic [7:0] old_val,
                                           input logic [7:0] new_val,
                                           input logic [7:0] mask);
    merge_bits = (old_val & ~mask) | (new_val & mask);
  endfunction

  // Assemble the status word from its stored fields.
  function automatic logic [7:0] pack_psw(input csr_state_t s);
    logic [7:0] w;
    w = 8'h00;
    w[CSR_PSW_CARRY]  = s.carry;
    w[CSR_PSW_AUX]    = s.aux_carry;
    w[CSR_PSW_USER0]  = s.user0;
    w[CSR_PSW_BANK_H] = s.bank[1];
    w[CSR_PSW_BANK_L] = s.bank[0];
    w[CSR_PSW_OVFL]   = s.ovfl;
    w[CSR_PSW_USER1]  = s.user1;
    w[CSR_PSW_PARITY] = s.parity;
    pack_psw = w;
  endfunction

  // Arithmetic and flag computation.
  csr_flag_unit u_flag_unit
  (
    .op_in      (ALU_OP_IN),
    .acc_in     (st_ff.accum),
    .operand_in (ALU_OPERAND_IN),
    .carry_in   (st_ff.carry),
    .aux_in     (st_ff.aux_carry),
    .ovfl_in    (st_ff.ovfl),
    .res_out    (alu_res)
  );

  // Bit access is only honoured where the low address nibble allows it;
  // elsewhere a bit write is dropped entirely rather than widened.
  always_comb
  begin
    bit_ok  = (SFR_ADDR_IN[3:0] == CSR_BIT_NIB_A) ||
              (SFR_ADDR_IN[3:0] == CSR_BIT_NIB_B);
    wr_en   = SFR_WR_IN && (!SFR_BIT_IN || bit_ok);
    wr_mask = SFR_BIT_IN ? (8'h01 << SFR_BIT_POS_IN) : 8'hFF;
    wr_val  = SFR_BIT_IN ? ({8{SFR_WDATA_IN[0]}}) : SFR_WDATA_IN;
    psw_now = pack_psw(st_ff);
    psw_new = merge_bits(psw_now, wr_val, wr_mask);
  end

  // Next-state logic: software writes first, then core operations.
  always_comb
  begin
    nxt_st = st_ff;

    // Software writes through direct addressing.
    if (wr_en)
    begin
      case (SFR_ADDR_IN)
        CSR_ADDR_STACK_TOP:
        begin
          nxt_st.stack_top = merge_bits(st_ff.stack_top, wr_val, wr_mask);
        end
        CSR_ADDR_DATA_POINTER_LOW:
        begin
          nxt_st.data_pointer_low = merge_bits(st_ff.data_pointer_low, wr_val, wr_mask);
        end
        CSR_ADDR_DATA_POINTER_HIGH:
        begin
          nxt_st.data_pointer_high = merge_bits(st_ff.data_pointer_high, wr_val, wr_mask);
        end
        CSR_ADDR_STATUS:
        begin
          // The parity position is not taken from the write.
          nxt_st.carry     = psw_new[CSR_PSW_CARRY];
          nxt_st.aux_carry = psw_new[CSR_PSW_AUX];
          nxt_st.user0     = psw_new[CSR_PSW_USER0];
          nxt_st.bank      = {psw_new[CSR_PSW_BANK_H],
                              psw_new[CSR_PSW_BANK_L]};
          nxt_st.ovfl      = psw_new[CSR_PSW_OVFL];
          nxt_st.user1     = psw_new[CSR_PSW_USER1];
        end
        CSR_ADDR_ACCUM:
        begin
          nxt_st.accum = merge_bits(st_ff.accum, wr_val, wr_mask);
        end
        default:
        begin
          // Undefined addresses belong to other blocks; nothing changes here.
          nxt_st = nxt_st;
        end
      endcase
    end

    // Arithmetic wins over a same-cycle software write to the same fields,
    // because the core's result is the later event in program order.
    if (alu_res.valid)
    begin
      nxt_st.accum     = alu_res.result;
      nxt_st.carry     = alu_res.carry;
      nxt_st.aux_carry = alu_res.aux_carry;
      nxt_st.ovfl      = alu_res.ovfl;
      nxt_st.alu_aux   = alu_res.aux;
    end

    // Stack pointer moves on push or pop; push raises it first so the
    // pointer names the slot that the pushed byte goes into.
    if (PUSH_IN && !POP_IN)
    begin
      nxt_st.stack_top = st_ff.stack_top + 8'h01;
    end
    else if (POP_IN && !PUSH_IN)
    begin
      nxt_st.stack_top = st_ff.stack_top - 8'h01;
    end
    else
    begin
      nxt_st.stack_top = nxt_st.stack_top;
    end

    // Parity always follows the accumulator value being stored.
    nxt_st.parity = odd_parity(nxt_st.accum);

    // Read data show the state before this cycle's updates.
    nxt_st.rd_hit  = 1'b0;
    nxt_st.rd_data = 8'h00;
    if (SFR_RD_IN)
    begin
      case (SFR_ADDR_IN)
        CSR_ADDR_STACK_TOP:
        begin
          nxt_st.rd_data = st_ff.stack_top;
          nxt_st.rd_hit  = 1'b1;
        end
        CSR_ADDR_DATA_POINTER_LOW:
        begin
          nxt_st.rd_data = st_ff.data_pointer_low;
          nxt_st.rd_hit  = 1'b1;
        end
        CSR_ADDR_DATA_POINTER_HIGH:
        begin
          nxt_st.rd_data = st_ff.data_pointer_high;
          nxt_st.rd_hit  = 1'b1;
        end
        CSR_ADDR_STATUS:
        begin
          nxt_st.rd_data = psw_now;
          nxt_st.rd_hit  = 1'b1;
        end
        CSR_ADDR_ACCUM:
        begin
          nxt_st.rd_data = st_ff.accum;
          nxt_st.rd_hit  = 1'b1;
        end
        default:
        begin
          // Unmapped here: read zero and leave the hit low.
          nxt_st.rd_data = 8'h00;
          nxt_st.rd_hit  = 1'b0;
        end
      endcase
    end
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      st_ff           <= '0;
      st_ff.accum     <= CSR_RST_ACCUM;
      st_ff.stack_top <= CSR_RST_STACK_TOP;
      st_ff.data_pointer_low  <= CSR_RST_DATA_POINTER_LOW;
      st_ff.data_pointer_high <= CSR_RST_DATA_POINTER_HIGH;
      st_ff.carry     <= CSR_RST_STATUS[CSR_PSW_CARRY];
      st_ff.aux_carry <= CSR_RST_STATUS[CSR_PSW_AUX];
      st_ff.user0     <= CSR_RST_STATUS[CSR_PSW_USER0];
      st_ff.bank      <= CSR_RST_STATUS[CSR_PSW_BANK_H:CSR_PSW_BANK_L];
      st_ff.ovfl      <= CSR_RST_STATUS[CSR_PSW_OVFL];
      st_ff.user1     <= CSR_RST_STATUS[CSR_PSW_USER1];
      st_ff.parity    <= CSR_RST_STATUS[CSR_PSW_PARITY];
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state flip-flops.
  always_comb
  begin
    SFR_RDATA_OUT    = st_ff.rd_data;
    SFR_RD_HIT_OUT   = st_ff.rd_hit;
    ALU_AUX_OUT      = st_ff.alu_aux;
    DATA_POINTER_OUT = {st_ff.data_pointer_high, st_ff.data_pointer_low};
    STACK_TOP_OUT    = st_ff.stack_top;
    ACCUMULATOR_OUT  = st_ff.accum;
    STATUS_WORD_OUT  = pack_psw(st_ff);
    // Bank base address is bank number times eight.
    BANK_BASE_OUT    = {3'b000, st_ff.bank, 3'b000};
  end

endmodule : csr_core_regs // csr_core_regs

`default_nettype wire

// ### rtl/csr_flag_unit.sv
// Purpose: Arithmetic result and flag computation for the register block.
// Assumes: Purely combinational; the caller registers every output.
// Notes:   Flags not touched by an operation are passed through unchanged.
`default_nettype none

module csr_flag_unit
  import csr_pkg::*;
(
  // Operation request.
  input  wire csr_alu_op_t  op_in,
  input  wire logic [7:0]   acc_in,
  input  wire logic [7:0]   operand_in,
  input  wire logic         carry_in,
  input  wire logic         aux_in,
  input  wire logic         ovfl_in,
  // Computed outcome.
  output csr_alu_res_t      res_out
);

  // Wide intermediates so no carry bit is lost.
  logic [8:0]  sum9;    // Full sum or difference with carry out.
  logic [4:0]  nib5;    // Low nibble sum or difference.
  logic [15:0] prod16;  // Full product.
  logic        cin;     // Carry used by the operation.

  // One combinational process covers every operation.
  always_comb
  begin
    res_out = '0;
    res_out.result    = acc_in;
    res_out.carry     = carry_in;
    res_out.aux_carry = aux_in;
    res_out.ovfl      = ovfl_in;
    cin    = (op_in == CSR_OP_ADD) ? 1'b0 : carry_in;
    sum9   = '0;
    nib5   = '0;
    prod16 = '0;
    case (op_in)
      CSR_OP_ADD, CSR_OP_ADDC:
      begin
        // Carry out of bit 7 and of bit 3 give the two carry flags.
        sum9 = {1'b0, acc_in} + {1'b0, operand_in} + {8'h00, cin};
        nib5 = {1'b0, acc_in[3:0]} + {1'b0, operand_in[3:0]} + {4'h0, cin};
        res_out.valid     = 1'b1;
        res_out.result    = sum9[7:0];
        res_out.carry     = sum9[8];
        res_out.aux_carry = nib5[4];
        // Sign change when both operands agree and the result differs.
        res_out.ovfl = (acc_in[7] == operand_in[7]) &&
                       (sum9[7] != acc_in[7]);
      end
      CSR_OP_SUBB:
      begin
        // A borrow shows as the top bit of the widened difference.
        sum9 = {1'b0, acc_in} - {1'b0, operand_in} - {8'h00, cin};
        nib5 = {1'b0, acc_in[3:0]} - {1'b0, operand_in[3:0]} - {4'h0, cin};
        res_out.valid     = 1'b1;
        res_out.result    = sum9[7:0];
        res_out.carry     = sum9[8];
        res_out.aux_carry = nib5[4];
        res_out.ovfl = (acc_in[7] != operand_in[7]) &&
                       (sum9[7] != acc_in[7]);
      end
      CSR_OP_MUL:
      begin
        prod16 = {8'h00, acc_in} * {8'h00, operand_in};
        res_out.valid     = 1'b1;
        res_out.result    = prod16[7:0];
        res_out.aux       = prod16[15:8];
        res_out.carry     = 1'b0;
        res_out.aux_carry = 1'b0;
        res_out.ovfl      = (prod16 > CSR_MUL_BYTE_MAX);
      end
      CSR_OP_DIV:
      begin
        res_out.valid     = 1'b1;
        res_out.carry     = 1'b0;
        res_out.aux_carry = 1'b0;
        if (operand_in == 8'h00)
        begin
          // Divide by zero leaves the accumulator alone and flags overflow.
          res_out.ovfl = 1'b1;
        end
        else
        begin
          res_out.result = acc_in / operand_in;
          res_out.aux    = acc_in % operand_in;
          res_out.ovfl   = 1'b0;
        end
      end
      default:
      begin
        // No operation: every flag keeps its value.
        res_out.valid = 1'b0;
      end
    endcase
  end

endmodule : csr_flag_unit // csr_flag_unit

`default_nettype wire

// ### rtl/csr_pkg.sv
// Purpose: Shared constants and types for the core special register block.
// Assumes: 8-bit data path and 8-bit special register address space.
// Notes:   Every offset, field position, reset value and encoding lives here.
`default_nettype none

package csr_pkg;

  // Data width of every special register in this block.
  localparam int CSR_DATA_W = 8;

  // Special register addresses reached by direct addressing.
  localparam logic [7:0] CSR_ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] CSR_ADDR_DATA_POINTER_LOW  = 8'h82;
  localparam logic [7:0] CSR_ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] CSR_ADDR_STATUS    = 8'hD0;
  localparam logic [7:0] CSR_ADDR_ACCUM     = 8'hE0;

  // Low address nibbles that allow single-bit access.
  localparam logic [3:0] CSR_BIT_NIB_A = 4'h0;
  localparam logic [3:0] CSR_BIT_NIB_B = 4'h8;

  // Reset values.
  localparam logic [7:0] CSR_RST_STACK_TOP = 8'h07;
  localparam logic [7:0] CSR_RST_DATA_POINTER_LOW  = 8'h00;
  localparam logic [7:0] CSR_RST_DATA_POINTER_HIGH = 8'h00;
  localparam logic [7:0] CSR_RST_STATUS    = 8'h00;
  localparam logic [7:0] CSR_RST_ACCUM     = 8'h00;

  // Field positions inside the program status word.
  localparam int CSR_PSW_CARRY  = 7;
  localparam int CSR_PSW_AUX    = 6;
  localparam int CSR_PSW_USER0  = 5;
  localparam int CSR_PSW_BANK_H = 4;
  localparam int CSR_PSW_BANK_L = 3;
  localparam int CSR_PSW_OVFL   = 2;
  localparam int CSR_PSW_USER1  = 1;
  localparam int CSR_PSW_PARITY = 0;

  // Largest product that still fits in one byte.
  localparam logic [15:0] CSR_MUL_BYTE_MAX = 16'h00FF;

  // Arithmetic operations the core may ask for.
  typedef enum logic [2:0] {
    CSR_OP_NONE,
    CSR_OP_ADD,
    CSR_OP_ADDC,
    CSR_OP_SUBB,
    CSR_OP_MUL,
    CSR_OP_DIV
  } csr_alu_op_t;

  // Result of one arithmetic operation with its flag effects.
  typedef struct packed {
    logic       valid;     // An arithmetic operation was carried out.
    logic [7:0] result;    // New accumulator value.
    logic [7:0] aux;       // Product high byte or division remainder.
    logic       carry;     // New carry flag.
    logic       aux_carry; // New auxiliary carry flag.
    logic       ovfl;      // New overflow flag.
  } csr_alu_res_t;

  // Complete state of the register block.
  typedef struct packed {
    logic [7:0]  accum;      // Accumulator.
    logic [7:0]  stack_top;  // Stack top pointer.
    logic [7:0]  data_pointer_low;   // Data pointer low byte.
    logic [7:0]  data_pointer_high;  // Data pointer high byte.
    logic        carry;      // Carry flag.
    logic        aux_carry;  // Auxiliary carry flag.
    logic        user0;      // User flag zero.
    logic [1:0]  bank;       // Working register bank select.
    logic        ovfl;       // Overflow flag.
    logic        user1;      // User flag one.
    logic        parity;     // Parity of the accumulator.
    logic [7:0]  rd_data;    // Registered read data.
    logic        rd_hit;     // Registered read hit indication.
    logic [7:0]  alu_aux;    // Registered auxiliary arithmetic result.
  } csr_state_t;

endpackage : csr_pkg

`default_nettype wire

// ### verif/csr_core_regs_props.sv
// Purpose: Port-level assertions for the core special register block.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every instance of the block; silent unless a check fails.
`default_nettype none

module csr_core_regs_props
  import csr_pkg::*;
#(
  parameter int DATA_W = CSR_DATA_W  // Handed on from the block.
)
(
  // Clock and reset.
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  // Register access.
  input wire logic [7:0]  SFR_ADDR_IN,
  input wire logic        SFR_WR_IN,
  input wire logic        SFR_RD_IN,
  input wire logic [7:0]  SFR_WDATA_IN,
  input wire logic        SFR_BIT_IN,
  input wire logic [2:0]  SFR_BIT_POS_IN,
  input wire logic [7:0]  SFR_RDATA_OUT,
  input wire logic        SFR_RD_HIT_OUT,
  // Arithmetic and stack.
  input wire csr_alu_op_t ALU_OP_IN,
  input wire logic [7:0]  ALU_OPERAND_IN,
  input wire logic [7:0]  ALU_AUX_OUT,
  input wire logic        PUSH_IN,
  input wire logic        POP_IN,
  // Register views.
  input wire logic [15:0] DATA_POINTER_OUT,
  input wire logic [7:0]  STACK_TOP_OUT,
  input wire logic [7:0]  ACCUMULATOR_OUT,
  input wire logic [7:0]  STATUS_WORD_OUT,
  input wire logic [7:0]  BANK_BASE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;

  // All checks use the core clock; reset silences them unless told otherwise.
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // A read of the accumulator with no read in the cycle after it.
  sequence s_lone_read;
    SFR_RD_IN && SFR_ADDR_IN == CSR_ADDR_ACCUM ##1 !SFR_RD_IN;
  endsequence

  // The old accumulator value is returned, and the hit drops a cycle later.
  sequence s_read_answer;
    SFR_RD_HIT_OUT && SFR_RDATA_OUT == $past(ACCUMULATOR_OUT) ##1 !SFR_RD_HIT_OUT;
  endsequence

  a_reset_load :
  assert property (disable iff (1'b0) !RST_N_IN |=> STACK_TOP_OUT == CSR_RST_STACK_TOP
    && DATA_POINTER_OUT == 16'h0000 && ACCUMULATOR_OUT == CSR_RST_ACCUM)
    else $error("Registers missed their reset values.");

  a_read_one_cycle :
  assert property (s_lone_read |-> s_read_answer)
    else $error("Accumulator read answer wrong.");

  a_stack_push :
  assert property (PUSH_IN && !POP_IN |=> STACK_TOP_OUT == $past(STACK_TOP_OUT) + 8'h01)
    else $error("Stack pointer missed its push step.");

  a_user_flags :
  assert property (!(SFR_WR_IN && SFR_ADDR_IN == CSR_ADDR_STATUS)
    |=> $stable({STATUS_WORD_OUT[5:3], STATUS_WORD_OUT[1]}))
    else $error("User flag or bank changed without a write.");

  a_parity_odd :
  assert property (STATUS_WORD_OUT[0] == ^ACCUMULATOR_OUT)
    else $error("Parity flag disagrees with accumulator.");

  a_add_flags :
  assert property (ALU_OP_IN == CSR_OP_ADD |=> {STATUS_WORD_OUT[7], ACCUMULATOR_OUT}
    == {1'b0, $past(ACCUMULATOR_OUT)} + {1'b0, $past(ALU_OPERAND_IN)}
    && STATUS_WORD_OUT[6] == ({1'b0, $past(ACCUMULATOR_OUT[3:0])}
    + {1'b0, $past(ALU_OPERAND_IN[3:0])} > 5'h0F)
    && STATUS_WORD_OUT[2] == ($past(ACCUMULATOR_OUT[7]) == $past(ALU_OPERAND_IN[7])
    && ACCUMULATOR_OUT[7] != $past(ACCUMULATOR_OUT[7])))
    else $error("Addition result or flags wrong.");

  a_mul_ovfl :
  assert property (ALU_OP_IN == CSR_OP_MUL |=> {ALU_AUX_OUT, ACCUMULATOR_OUT}
    == {8'h00, $past(ACCUMULATOR_OUT)} * {8'h00, $past(ALU_OPERAND_IN)}
    && STATUS_WORD_OUT[2] == ({ALU_AUX_OUT, ACCUMULATOR_OUT} > CSR_MUL_BYTE_MAX))
    else $error("Product or its overflow flag wrong.");

  a_div_zero :
  assert property (ALU_OP_IN == CSR_OP_DIV && ALU_OPERAND_IN == 8'h00
    |=> STATUS_WORD_OUT[2] && $stable(ACCUMULATOR_OUT))
    else $error("Divide by zero not flagged.");

  a_bit_refused :
  assert property (SFR_WR_IN && SFR_BIT_IN && SFR_ADDR_IN == CSR_ADDR_STACK_TOP
    && PUSH_IN == POP_IN |=> $stable(STACK_TOP_OUT))
    else $error("Bit write took effect at a byte-only address.");

endmodule // csr_core_regs_props

bind csr_core_regs csr_core_regs_props #(.DATA_W(DATA_W)) u_props (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .SFR_ADDR_IN(SFR_ADDR_IN),
  .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
  .SFR_BIT_IN(SFR_BIT_IN), .SFR_BIT_POS_IN(SFR_BIT_POS_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT),
  .SFR_RD_HIT_OUT(SFR_RD_HIT_OUT), .ALU_OP_IN(ALU_OP_IN), .ALU_OPERAND_IN(ALU_OPERAND_IN),
  .ALU_AUX_OUT(ALU_AUX_OUT), .PUSH_IN(PUSH_IN), .POP_IN(POP_IN),
  .DATA_POINTER_OUT(DATA_POINTER_OUT), .STACK_TOP_OUT(STACK_TOP_OUT),
  .ACCUMULATOR_OUT(ACCUMULATOR_OUT), .STATUS_WORD_OUT(STATUS_WORD_OUT),
  .BANK_BASE_OUT(BANK_BASE_OUT)
);

`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the core special register block.
// Assumes: 20 MHz clock; inputs change 1 ns after each rising edge.
// Notes:   An integer model predicts every output after every edge, the auxiliary byte only after multiply, divide or reset.
`default_nettype none

module tb_top
  import csr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;                    // Core clock.
  logic        rst_n = 1'b0;                  // Reset, active low.
  logic [7:0]  adr = 8'h00, wd = 8'h00;       // Access address and data.
  logic [7:0]  opnd = 8'h00;                  // Second arithmetic operand.
  logic        wr = 1'b0, rd = 1'b0, bt = 1'b0; // Access strobes.
  logic        psh = 1'b0, pp = 1'b0;         // Stack requests.
  logic [2:0]  pos = 3'h0;                    // Bit position.
  csr_alu_op_t op = CSR_OP_NONE;              // Arithmetic request.
  logic [7:0]  rdat, aux, sp_o, acc_o, psw_o, base_o; // Observed outputs.
  logic        hit;                           // Observed read hit.
  logic [15:0] dp_o;                          // Observed data pointer.
  int          num_errors = 0;                // Mismatches seen.
  int          cmp_count = 0;                 // Comparisons made.
  logic [31:0] seed = 32'h9550;               // Random state.
  int          m_acc, m_sp, m_dpl, m_dph, m_psw, m_aux, e_rd, e_hit; // Model state.
  logic [7:0]  tbl [8] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'h84, 8'h80, 8'hD1};
  logic [7:0]  ta [11] = '{8'h7F, 8'hFF, 8'hFF, 8'h00, 8'h80, 8'h0F, 8'h10, 8'h0F,
                           8'hC8, 8'hC8, 8'h3C};
  logic [7:0]  tb [11] = '{8'h01, 8'h01, 8'hFF, 8'h01, 8'h01, 8'h01, 8'h10, 8'h11,
                           8'h00, 8'h07, 8'h0F};
  csr_alu_op_t to [11] = '{CSR_OP_ADD, CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB, CSR_OP_SUBB,
                           CSR_OP_ADD, CSR_OP_MUL, CSR_OP_MUL, CSR_OP_DIV, CSR_OP_DIV,
                           CSR_OP_SUBB};

  // Half-period toggle gives 50 ns.
  always #25 clk = ~clk;

  csr_core_regs dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SFR_ADDR_IN(adr), .SFR_WR_IN(wr),
    .SFR_RD_IN(rd), .SFR_WDATA_IN(wd), .SFR_BIT_IN(bt), .SFR_BIT_POS_IN(pos),
    .SFR_RDATA_OUT(rdat), .SFR_RD_HIT_OUT(hit), .ALU_OP_IN(op), .ALU_OPERAND_IN(opnd),
    .ALU_AUX_OUT(aux), .PUSH_IN(psh), .POP_IN(pp), .DATA_POINTER_OUT(dp_o),
    .STACK_TOP_OUT(sp_o), .ACCUMULATOR_OUT(acc_o), .STATUS_WORD_OUT(psw_o),
    .BANK_BASE_OUT(base_o)
  );

  // Xorshift keeps the run repeatable from the fixed seed.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Model read value; -1 marks an unmapped address.
  function automatic int rv(input logic [7:0] a);
    case (a)
      CSR_ADDR_STACK_TOP: return m_sp;
      CSR_ADDR_DATA_POINTER_LOW:  return m_dpl;
      CSR_ADDR_DATA_POINTER_HIGH: return m_dph;
      CSR_ADDR_STATUS:    return m_psw | int'(^8'(m_acc));
      CSR_ADDR_ACCUM:     return m_acc;
      default:            return -1;
    endcase
  endfunction

  // Loads the accumulator and the three arithmetic flags of the model.
  function automatic void setf(input int r, input int cy, input int ac, input int ov);
    m_acc = r & 255;
    m_psw = (m_psw & 59) | (cy << 7) | (ac << 6) | (ov << 2);
  endfunction

  // Reports and counts a difference.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Drives one cycle, steps the model and compares every output, the auxiliary byte only after multiply, divide or reset.
  task automatic cyc(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d,
                     input csr_alu_op_t o, input logic [7:0] b, input logic [1:0] st,
                     input logic bi, input logic [2:0] ps);
    int v, x, k, c, s;
    adr = a;
    wr = w;
    rd = r;
    wd = d;
    op = o;
    opnd = b;
    psh = st[1];
    pp = st[0];
    bt = bi;
    pos = ps;
    v = rv(a);
    k = m_acc;
    c = (m_psw >> 7) & 1;
    x = bi ? ((v & ~(1 << ps)) | (int'(d[0]) << ps)) : int'(d);
    e_hit = (r && v >= 0) ? 1 : 0;
    e_rd = e_hit ? v : 0;
    m_aux = -1;
    // Bit writes only land at addresses ending in 0 or 8.
    if (w && (!bi || a[2:0] == 3'h0))
      case (a)
        CSR_ADDR_STACK_TOP: if (st[1] == st[0]) m_sp = x;
        CSR_ADDR_DATA_POINTER_LOW:  m_dpl = x;
        CSR_ADDR_DATA_POINTER_HIGH: m_dph = x;
        CSR_ADDR_STATUS:    m_psw = x & 254;
        CSR_ADDR_ACCUM:     m_acc = x;
        default: ;
      endcase
    // Arithmetic reads the registered values and beats a same-cycle write.
    case (o)
      CSR_OP_ADD, CSR_OP_ADDC:
      begin
        c = (o == CSR_OP_ADDC) ? c : 0;
        s = k + b + c;
        setf(s, s > 255, k % 16 + b % 16 + c > 15, k / 128 == b / 128 && (s & 255) / 128 != k / 128);
      end
      CSR_OP_SUBB:
      begin
        s = k - b - c;
        setf(s, s < 0, k % 16 < b % 16 + c, k / 128 != b / 128 && (s & 255) / 128 != k / 128);
      end
      CSR_OP_MUL:
      begin
        m_aux = (k * b) / 256;
        setf(k * b, 0, 0, k * b > 255);
      end
      CSR_OP_DIV:
      begin
        m_aux = (b == 0) ? 0 : k % b;
        setf((b == 0) ? k : k / b, 0, 0, b == 0);
      end
      default: ;
    endcase
    // Stack requests beat a same-cycle pointer write.
    if (st == 2'b10)
      m_sp = (m_sp + 1) % 256;
    else if (st == 2'b01)
      m_sp = (m_sp + 255) % 256;
    if (!rst_n)
    begin
      m_acc = 0;
      m_sp = 7;
      m_dpl = 0;
      m_dph = 0;
      m_psw = 0;
      m_aux = 0;
      e_rd = 0;
      e_hit = 0;
    end
    @(posedge clk);
    #1;
    chk(acc_o, 16'(m_acc));
    chk(sp_o, 16'(m_sp));
    chk(dp_o, 16'(m_dph * 256 + m_dpl));
    chk(psw_o, 16'(rv(CSR_ADDR_STATUS)));
    chk(base_o, 16'(m_psw & 24));
    chk({7'h00, hit, rdat}, 16'(e_hit * 256 + e_rd));
    if (m_aux >= 0)
      chk({8'h00, aux}, 16'(m_aux));
  endtask

  // One quiet cycle.
  task automatic idle();
    cyc(8'h00, 1'b0, 1'b0, 8'h00, CSR_OP_NONE, 8'h00, 2'b00, 1'b0, 3'h0);
  endtask

  // Prints the verdict and stops.
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short well beyond the roughly 600 cycles of the run.
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial
  begin
    logic [31:0] r;
    repeat (2) idle();
    rst_n = 1'b1;
    idle();
    // Back-to-back reads of every mapped address and three unmapped ones.
    foreach (tbl[i]) cyc(tbl[i], 1'b0, 1'b1, 8'h00, CSR_OP_NONE, 8'h00, 2'b00, 1'b0, 3'h0);
    // Writes, then a write with a read in the same cycle, then a read.
    foreach (tbl[i])
    begin
      cyc(tbl[i], 1'b1, 1'b0, 8'(rnd()) | 8'h01, CSR_OP_NONE, 8'h00, 2'b00, 1'b0, 3'h0);
      cyc(tbl[i], 1'b1, 1'b1, 8'(rnd()), CSR_OP_NONE, 8'h00, 2'b00, 1'b0, 3'h0);
      cyc(tbl[i], 1'b0, 1'b1, 8'h00, CSR_OP_NONE, 8'h00, 2'b00, 1'b0, 3'h0);
    end
    // Single-bit writes to every position of bit-capable and byte-only places.
    for (int p = 0; p < 16; p++)
      foreach (tbl[i]) cyc(tbl[i], 1'b1, 1'b0, 8'(p / 8), CSR_OP_NONE, 8'h00, 2'b00, 1'b1, 3'(p));
    // Pointer write of 0xFF, push over a pointer write, pops, a push and a cancelled pair.
    cyc(CSR_ADDR_STACK_TOP, 1'b1, 1'b0, 8'hFF, CSR_OP_NONE, 8'h00, 2'b00, 1'b0, 3'h0);
    cyc(CSR_ADDR_STACK_TOP, 1'b1, 1'b0, 8'h40, CSR_OP_NONE, 8'h00, 2'b10, 1'b0, 3'h0);
    for (int s = 0; s < 6; s++)
      cyc(8'h00, 1'b0, 1'b0, 8'h00, CSR_OP_NONE, 8'h00, 2'(s % 4), 1'b0, 3'h0);
    // Boundary arithmetic cases with a fresh accumulator before each.
    foreach (ta[i])
    begin
      cyc(CSR_ADDR_ACCUM, 1'b1, 1'b0, ta[i], CSR_OP_NONE, 8'h00, 2'b00, 1'b0, 3'h0);
      cyc(8'h00, 1'b0, 1'b0, 8'h00, to[i], tb[i], 2'b00, 1'b0, 3'h0);
    end
    // Mixed random traffic on every input except clock and reset.
    repeat (400)
    begin
      r = rnd();
      cyc(tbl[r[2:0]], r[3], r[4], r[15:8], csr_alu_op_t'(3'(r[31:24] % 6)), r[23:16],
          r[6:5], r[7], r[27:25]);
    end
    // A second reset in mid-run.
    rst_n = 1'b0;
    repeat (2) idle();
    rst_n = 1'b1;
    repeat (2) idle();
    finish_test();
  end

endmodule // tb_top

`default_nettype wire
